// ---- usdbr_far_end.sv ----
`timescale 1ns/1ps
// ****************************************
// far-end serial device model
// ****************************************
module usdbr_far_end
   import usdbr_pkg::*;
(
   input  wire logic      aclk,
   output usdbr_rx_word_t rx_word,
   output logic           tx_take,
   output logic           tx_frame_done,
   output logic           line_idle,
   output logic           line_break,
   output logic           cts_pin_n
);
   initial begin
      rx_word = '{1'b0, 9'h1FF, 1'b0, 1'b0, 1'b0};
      {tx_take, tx_frame_done, line_idle, line_break} = 4'h0;
      cts_pin_n = 1'b1;
   end

   // one-cycle word strobe; data inverted after, so stale data never matches
   task automatic send(input logic [8:0] d, input logic n, input logic f, input logic p);
      @(posedge aclk);
      rx_word <= '{1'b1, d, n, f, p};
      @(posedge aclk);
      rx_word <= '{1'b0, ~d, 1'b0, 1'b0, 1'b0};
   endtask : send

   // k: 0 shifter take, 1 frame done, 2 idle line, 3 break
   task automatic strobe(input int k);
      @(posedge aclk);
      {tx_take, tx_frame_done, line_idle, line_break} <= 4'h8 >> k;
      @(posedge aclk);
      {tx_take, tx_frame_done, line_idle, line_break} <= 4'h0;
   endtask : strobe

   task automatic cts_flip;
      @(posedge aclk);
      cts_pin_n <= ~cts_pin_n;
   endtask : cts_flip
endmodule : usdbr_far_end

// ---- usdbr_pkg.sv ----
package usdbr_pkg;

   // ****************************************
   // register map
   // ****************************************
   localparam logic [3:0]  LS_OFS      = 4'h0;
   localparam logic [3:0]  DATA_OFS    = 4'h4;
   localparam logic [3:0]  DIV_OFS     = 4'h8;
   localparam logic [3:0]  CTRL_OFS    = 4'hC;
   localparam logic [31:0] LS_RESET    = 32'h00C0_0000;
   localparam logic [15:0] DIV_RESET   = 16'h0000;
   localparam logic [15:0] CTRL_RESET  = 16'h0000;

   // ****************************************
   // status field positions
   // ****************************************
   localparam int CTS_B  = 9;
   localparam int BRK_B  = 8;
   localparam int TXE_B  = 7;
   localparam int TC_B   = 6;
   localparam int RX_HOLD_FULL_B = 5;
   localparam int IDLE_B = 4;
   localparam int ORE_B  = 3;
   localparam int NF_B   = 2;
   localparam int FE_B   = 1;
   localparam int PE_B   = 0;
   localparam logic [9:0] LS_W0_MASK  = 10'h360;
   localparam logic [9:0] LS_SEQ_MASK = 10'h01F;

   // ****************************************
   // divider and sampling
   // ****************************************
   localparam int         DIV_FRAC_W = 4;
   localparam int         DIV_INT_W  = 12;
   localparam logic [3:0] OS16_LAST  = 4'hF;
   localparam logic [3:0] OS8_LAST   = 4'h7;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic multibuf_err_irq_on;
      logic clear_to_send_irq_on;
      logic break_seen_irq_on;
      logic parity_fault_irq_on;
      logic line_quiet_irq_on;
      logic rx_hold_full_irq_on;
      logic tx_done_irq_on;
      logic tx_hold_empty_irq_on;
      logic multibuf;
      logic clear_to_send_flow_on;
      logic half_oversample;
      logic word9;
      logic parity_odd;
      logic parity_on;
      logic rx_on;
      logic tx_on;
   } usdbr_ctrl_t;

   typedef struct packed {
      logic       valid;
      logic [8:0] data;
      logic       noise;
      logic       framing;
      logic       parity;
   } usdbr_rx_word_t;

endpackage : usdbr_pkg

// ---- usdbr_regs.sv ----
`timescale 1ns/1ps
// How it works
// - with flow control on, each clear-to-send toggle sets its flag; zero write clears
// - detected break sets break_seen_flag; zero write clears; enable gates its interrupt
// - holding word taken by shifter sets tx_hold_empty; any data write clears
// - data frame finished while tx_hold_empty set raises tx_done
// - tx_done clears by status read then data write, or zero write
// - received word loaded sets rx_hold_full; data read or zero write clears
// - idle line sets line_quiet; status read then data read clears
// - line_quiet stays off after clearing until a new word fills the hold
// - word arriving while hold full sets overrun; rx_hold_full interrupt enable gates interrupt
// - on overrun the held word stays, the incoming word is dropped
// - noise sets noise_flag; sequence clears; no own interrupt in single buffer
// - framing fault set by receiver; sequence clears; no own single-buffer interrupt
// - framing plus overrun on one word sets only overrun
// - multibuffer mode: overrun, noise or framing interrupt when error enable set
// - parity error sets parity_fault; status read then data access clears
// - one data address: writes go to tx hold, reads return rx hold
// - parity on: top written data bit replaced by computed parity
// - parity on: received parity bit returned in top data bit
// - each baud counter halts while its direction enable is off
// - divider register: integer part bits 15:4, fraction bits 3:0
// - half oversample ignores fraction bit 3
// - sixteen samples per bit, or eight with half oversample
module usdbr_regs
   import usdbr_pkg::*;
#(
   parameter int ADDR_W = 4
) (
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic [ADDR_W-1:0] awaddr,
   input  wire logic           awvalid,
   output logic                awready,
   input  wire logic [31:0]    wdata,
   input  wire logic [3:0]     wstrb,
   input  wire logic           wvalid,
   output logic                wready,
   output logic [1:0]          bresp,
   output logic                bvalid,
   input  wire logic           bready,
   input  wire logic [ADDR_W-1:0] araddr,
   input  wire logic           arvalid,
   output logic                arready,
   output logic [31:0]         rdata,
   output logic [1:0]          rresp,
   output logic                rvalid,
   input  wire logic           rready,
   input  wire usdbr_rx_word_t rx_word,
   input  wire logic           tx_take,
   input  wire logic           tx_frame_done,
   input  wire logic           line_idle,
   input  wire logic           line_break,
   input  wire logic           cts_pin_n,
   output logic [8:0]          tx_word,
   output logic                tx_word_valid,
   output usdbr_ctrl_t         ctrl,
   output logic                tx_os_tick,
   output logic                rx_os_tick,
   output logic                tx_bit_tick,
   output logic                rx_bit_tick,
   output logic                irq_req
);

   if (ADDR_W < 4) begin : g_chk
      $error("ADDR_W below 4 cannot hold the map");
   end

   // ****************************************
   // bus slave
   // ****************************************
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [1:0]  rresp_reg;
   logic [31:0] rdata_reg;
   logic        wr_fire;
   logic        rd_fire;
   logic        wr_ls;
   logic        wr_dr;
   logic        wr_div;
   logic        wr_ctl;
   logic        rd_ls;
   logic        rd_dr;
   logic        rd_map;
   logic [31:0] wmask;
   logic [31:0] rd_val;

   assign wr_fire = awvalid & wvalid & ~bvalid_reg;
   assign awready = wr_fire;
   assign wready  = wr_fire;
   assign rd_fire = arvalid & ~rvalid_reg;
   assign arready = ~rvalid_reg;
   assign bvalid  = bvalid_reg;
   assign bresp   = bresp_reg;
   assign rvalid  = rvalid_reg;
   assign rresp   = rresp_reg;
   assign rdata   = rdata_reg;

   assign wr_ls  = wr_fire & (awaddr == ADDR_W'(LS_OFS));
   assign wr_dr  = wr_fire & (awaddr == ADDR_W'(DATA_OFS));
   assign wr_div = wr_fire & (awaddr == ADDR_W'(DIV_OFS));
   assign wr_ctl = wr_fire & (awaddr == ADDR_W'(CTRL_OFS));
   assign rd_ls  = rd_fire & (araddr == ADDR_W'(LS_OFS));
   assign rd_dr  = rd_fire & (araddr == ADDR_W'(DATA_OFS));
   assign rd_map = rd_ls | rd_dr | (araddr == ADDR_W'(DIV_OFS))
                 | (araddr == ADDR_W'(CTRL_OFS));
   assign wmask  = {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= (wr_ls | wr_dr | wr_div | wr_ctl) ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rresp_reg  <= RESP_OKAY;
         rdata_reg  <= 32'h0000_0000;
      end else if (rd_fire) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= rd_map ? RESP_OKAY : RESP_SLVERR;
         rdata_reg  <= rd_val;
      end else if (rready) begin
         rvalid_reg <= 1'b0;
      end
   end

   // ****************************************
   // control and divider
   // ****************************************
   usdbr_ctrl_t ctrl_reg;
   logic [15:0] div_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= usdbr_ctrl_t'(CTRL_RESET);
      end else if (wr_ctl) begin
         ctrl_reg <= usdbr_ctrl_t'((16'(ctrl_reg) & ~wmask[15:0]) | (wdata[15:0] & wmask[15:0]));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_reg <= DIV_RESET;
      end else if (wr_div) begin
         div_reg <= (div_reg & ~wmask[15:0]) | (wdata[15:0] & wmask[15:0]);
      end
   end

   assign ctrl = ctrl_reg;

   // ****************************************
   // clear-to-send input
   // ****************************************
   logic cts_meta_reg;
   logic cts_sync_reg;
   logic cts_last_reg;
   logic cts_toggle;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cts_meta_reg <= 1'b1;
         cts_sync_reg <= 1'b1;
         cts_last_reg <= 1'b1;
      end else begin
         cts_meta_reg <= cts_pin_n;
         cts_sync_reg <= cts_meta_reg;
         cts_last_reg <= cts_sync_reg;
      end
   end

   assign cts_toggle = cts_sync_reg ^ cts_last_reg;

   // ****************************************
   // status flags
   // ****************************************
   logic [9:0] status_reg;
   logic [9:0] status_next;
   logic       seq_reg;
   logic       idle_arm_reg;
   logic       hold_busy;
   logic       rx_load;
   logic       rx_over;

   // a read of data in the same cycle frees the hold for the new word
   assign hold_busy = status_reg[RX_HOLD_FULL_B] & ~rd_dr;
   assign rx_load   = rx_word.valid & ~hold_busy;
   assign rx_over   = rx_word.valid & hold_busy;

   always_comb begin
      status_next = status_reg;
      if (wr_ls) begin
         status_next = status_next & ~(wmask[9:0] & ~wdata[9:0] & LS_W0_MASK);
      end
      if (wr_dr) begin
         status_next[TXE_B] = 1'b0;
         if (seq_reg) begin
            status_next[TC_B] = 1'b0;
            status_next[PE_B] = 1'b0;
         end
      end
      if (rd_dr) begin
         status_next[RX_HOLD_FULL_B] = 1'b0;
         if (seq_reg) begin
            status_next = status_next & ~LS_SEQ_MASK;
         end
      end
      // sets come last so an event beats a clear in the same cycle
      if (ctrl_reg.clear_to_send_flow_on && cts_toggle) begin
         status_next[CTS_B] = 1'b1;
      end
      if (line_break) begin
         status_next[BRK_B] = 1'b1;
      end
      if (tx_take) begin
         status_next[TXE_B] = 1'b1;
      end
      if (tx_frame_done && status_reg[TXE_B]) begin
         status_next[TC_B] = 1'b1;
      end
      if (line_idle && idle_arm_reg) begin
         status_next[IDLE_B] = 1'b1;
      end
      if (rx_over) begin
         status_next[ORE_B] = 1'b1;
      end
      if (rx_load) begin
         status_next[RX_HOLD_FULL_B] = 1'b1;
         if (rx_word.noise) begin
            status_next[NF_B] = 1'b1;
         end
         if (rx_word.framing) begin
            status_next[FE_B] = 1'b1;
         end
         if (rx_word.parity) begin
            status_next[PE_B] = 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_reg <= LS_RESET[9:0];
      end else begin
         status_reg <= status_next;
      end
   end

   // status read arms the clear; the next data access spends it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_reg <= 1'b0;
      end else if (rd_dr || wr_dr) begin
         seq_reg <= 1'b0;
      end else if (rd_ls) begin
         seq_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idle_arm_reg <= 1'b0;
      end else if (rx_load) begin
         idle_arm_reg <= 1'b1;
      end else if (line_idle) begin
         idle_arm_reg <= 1'b0;
      end
   end

   // ****************************************
   // holding registers
   // ****************************************
   logic [8:0] tx_hold_reg;
   logic [8:0] rx_hold_reg;
   logic [8:0] tx_word_reg;
   logic [8:0] tx_word_next;
   logic [8:0] rx_view;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_hold_reg <= 9'h000;
      end else if (wr_dr) begin
         tx_hold_reg <= (tx_hold_reg & ~wmask[8:0]) | (wdata[8:0] & wmask[8:0]);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_hold_reg <= 9'h000;
      end else if (rx_load) begin
         rx_hold_reg <= rx_word.data;
      end
   end

   always_comb begin
      tx_word_next = tx_hold_reg;
      if (!ctrl_reg.word9) begin
         tx_word_next[8] = 1'b0;
      end
      if (ctrl_reg.parity_on && ctrl_reg.word9) begin
         tx_word_next[8] = ^tx_hold_reg[7:0] ^ ctrl_reg.parity_odd;
      end else if (ctrl_reg.parity_on) begin
         tx_word_next[7] = ^tx_hold_reg[6:0] ^ ctrl_reg.parity_odd;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_word_reg <= 9'h000;
      end else begin
         tx_word_reg <= tx_word_next;
      end
   end

   assign tx_word       = tx_word_reg;
   assign tx_word_valid = ~status_reg[TXE_B];
   assign rx_view       = {rx_hold_reg[8] & ctrl_reg.word9, rx_hold_reg[7:0]};

   always_comb begin
      rd_val = 32'h0000_0000;
      if (araddr == ADDR_W'(LS_OFS)) begin
         rd_val = {LS_RESET[31:10], status_reg};
      end else if (araddr == ADDR_W'(DATA_OFS)) begin
         rd_val = {23'h000000, rx_view};
      end else if (araddr == ADDR_W'(DIV_OFS)) begin
         rd_val = {16'h0000, div_reg};
      end else if (araddr == ADDR_W'(CTRL_OFS)) begin
         rd_val = {16'h0000, 16'(ctrl_reg)};
      end
   end

   // ****************************************
   // interrupt request
   // ****************************************
   logic irq_reg;
   logic irq_next;

   always_comb begin
      irq_next = (status_reg[CTS_B] & ctrl_reg.clear_to_send_irq_on)
               | (status_reg[BRK_B] & ctrl_reg.break_seen_irq_on)
               | (status_reg[TXE_B] & ctrl_reg.tx_hold_empty_irq_on)
               | (status_reg[TC_B] & ctrl_reg.tx_done_irq_on)
               | ((status_reg[RX_HOLD_FULL_B] | status_reg[ORE_B])
                  & ctrl_reg.rx_hold_full_irq_on)
               | (status_reg[IDLE_B] & ctrl_reg.line_quiet_irq_on)
               | (status_reg[PE_B] & ctrl_reg.parity_fault_irq_on)
               | (ctrl_reg.multibuf & ctrl_reg.multibuf_err_irq_on
                  & (status_reg[ORE_B] | status_reg[NF_B] | status_reg[FE_B]));
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= irq_next;
      end
   end

   assign irq_req = irq_reg;

   // ****************************************
   // baud generators
   // ****************************************
   logic [15:0] div_eff;
   logic [1:0]  ch_on;
   logic [1:0]  os_tick;
   logic [1:0]  bit_tick;
   logic [3:0]  os_last;

   // bit 3 of the fraction dropped so odd settings cannot skew x8 timing
   assign div_eff = ctrl_reg.half_oversample
                  ? {div_reg[15:4], 1'b0, div_reg[2:0]}
                  : div_reg;
   assign os_last = ctrl_reg.half_oversample ? OS8_LAST : OS16_LAST;
   assign ch_on   = {ctrl_reg.rx_on, ctrl_reg.tx_on};

   for (genvar g = 0; g < 2; g++) begin : g_baud
      logic [16:0] acc_reg;
      logic [16:0] acc_sum;
      logic [3:0]  os_cnt_reg;
      logic        os_reg;
      logic        bit_reg;
      logic        run;

      // integer part zero would need several ticks per clock, so it halts
      assign run     = ch_on[g] & (div_eff[15:4] != 12'h000);
      assign acc_sum = acc_reg + 17'h00010;

      always_ff @(posedge aclk) begin
         if (!aresetn || !run) begin
            acc_reg <= 17'h00000;
            os_reg  <= 1'b0;
         end else if (acc_sum >= {1'b0, div_eff}) begin
            acc_reg <= acc_sum - {1'b0, div_eff};
            os_reg  <= 1'b1;
         end else begin
            acc_reg <= acc_sum;
            os_reg  <= 1'b0;
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn || !run) begin
            os_cnt_reg <= 4'h0;
            bit_reg    <= 1'b0;
         end else if (os_reg && os_cnt_reg >= os_last) begin
            os_cnt_reg <= 4'h0;
            bit_reg    <= 1'b1;
         end else begin
            os_cnt_reg <= os_cnt_reg + {3'h0, os_reg};
            bit_reg    <= 1'b0;
         end
      end

      assign os_tick[g]  = os_reg;
      assign bit_tick[g] = bit_reg;
   end

   assign tx_os_tick  = os_tick[0];
   assign rx_os_tick  = os_tick[1];
   assign tx_bit_tick = bit_tick[0];
   assign rx_bit_tick = bit_tick[1];

   // ****************************************
   // checks
   // ****************************************
   property p_cts_flag;
      @(posedge aclk) disable iff (!aresetn)
      (ctrl_reg.clear_to_send_flow_on && cts_toggle) |=> status_reg[CTS_B];
   endproperty
   a_cts_flag: assert property (p_cts_flag) else $error("cts toggle lost");

   property p_txe_clear;
      @(posedge aclk) disable iff (!aresetn)
      (wr_dr && !tx_take) |=> !status_reg[TXE_B] && tx_word_valid;
   endproperty
   a_txe_clear: assert property (p_txe_clear) else $error("data write left txe");

   property p_tc_set;
      @(posedge aclk) disable iff (!aresetn)
      (tx_frame_done && status_reg[TXE_B]) |=> status_reg[TC_B];
   endproperty
   a_tc_set: assert property (p_tc_set) else $error("tx_done not set");

   property p_rx_load;
      @(posedge aclk) disable iff (!aresetn)
      rx_load |=> status_reg[RX_HOLD_FULL_B] && rx_hold_reg == $past(rx_word.data);
   endproperty
   a_rx_load: assert property (p_rx_load) else $error("received word not held");

   property p_idle_arm;
      @(posedge aclk) disable iff (!aresetn)
      $rose(status_reg[IDLE_B]) |-> $past(idle_arm_reg);
   endproperty
   a_idle_arm: assert property (p_idle_arm) else $error("idle set while disarmed");

   property p_overrun_keep;
      @(posedge aclk) disable iff (!aresetn)
      rx_over |=> status_reg[ORE_B] && $stable(rx_hold_reg);
   endproperty
   a_overrun_keep: assert property (p_overrun_keep) else $error("overrun lost hold");

   property p_fe_on_over;
      @(posedge aclk) disable iff (!aresetn)
      (rx_over && !status_reg[FE_B] && !rd_dr && !wr_ls) |=> !status_reg[FE_B];
   endproperty
   a_fe_on_over: assert property (p_fe_on_over) else $error("framing set on overrun");

   property p_tx_halt;
      @(posedge aclk) disable iff (!aresetn)
      !ctrl_reg.tx_on |=> !tx_os_tick ##0 !tx_bit_tick;
   endproperty
   a_tx_halt: assert property (p_tx_halt) else $error("tx baud ran while off");

endmodule : usdbr_regs

// ---- usdbr_regs_tb.sv ----
`timescale 1ns/1ps
module usdbr_regs_tb;
   import usdbr_pkg::*;
   // ****************************************
   // signals
   // ****************************************
   logic           aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic           awready, wready, bvalid, arready, rvalid;
   logic [3:0]     awaddr, araddr, wstrb;
   logic [31:0]    wdata, rdata;
   logic [1:0]     bresp, rresp;
   usdbr_rx_word_t rx_word;
   usdbr_ctrl_t    ctrl;
   logic           tx_take, tx_frame_done, line_idle, line_break, cts_pin_n;
   logic [8:0]     tx_word;
   logic           tx_word_valid, tx_os_tick, rx_os_tick, tx_bit_tick, rx_bit_tick, irq_req;
   int             mismatches = 0;
   int             n_compared = 0;
   localparam logic [31:0] LS = LS_RESET;

   usdbr_regs #(.ADDR_W(4)) usdbr_regs_inst (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .rx_word(rx_word), .tx_take(tx_take),
      .tx_frame_done(tx_frame_done), .line_idle(line_idle), .line_break(line_break),
      .cts_pin_n(cts_pin_n), .tx_word(tx_word), .tx_word_valid(tx_word_valid), .ctrl(ctrl),
      .tx_os_tick(tx_os_tick), .rx_os_tick(rx_os_tick), .tx_bit_tick(tx_bit_tick),
      .rx_bit_tick(rx_bit_tick), .irq_req(irq_req));
   usdbr_far_end usdbr_far_end_inst (.aclk(aclk), .rx_word(rx_word), .tx_take(tx_take),
      .tx_frame_done(tx_frame_done), .line_idle(line_idle), .line_break(line_break),
      .cts_pin_n(cts_pin_n));

   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   // ****************************************
   // bus and compare helpers
   // ****************************************
   // request held until ready is seen at a rising edge; answer taken at its edge
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, RESP_OKAY});
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      d = rdata;
      rready <= 1'b0;
      chk({30'h0, rresp}, {30'h0, RESP_OKAY});
   endtask : rd

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk

   task automatic rdc(input logic [3:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(v, e);
   endtask : rdc

   // count ticks over n cycles; tolerance of one covers start-up phase
   task automatic ticks(input int n, output int t, output int b);
      t = 0;
      b = 0;
      repeat (n) begin
         @(negedge aclk);
         t += int'(tx_os_tick);
         b += int'(rx_bit_tick);
      end
   endtask : ticks

   function automatic logic [31:0] nr(input int t, input int e);
      return (t >= e - 1 && t <= e + 1) ? 32'(e) : 32'(t);
   endfunction : nr

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_rx;
      usdbr_far_end_inst.send(9'h011, 1'b0, 1'b0, 1'b0);
      rdc(LS_OFS, LS | 32'h20);
      usdbr_far_end_inst.send(9'h122, 1'b0, 1'b1, 1'b0);
      rdc(LS_OFS, LS | 32'h28);
      rdc(DATA_OFS, 32'h11);
      rdc(LS_OFS, LS);
   endtask : t_rx

   task automatic t_idle;
      usdbr_far_end_inst.send(9'h033, 1'b0, 1'b0, 1'b0);
      rdc(DATA_OFS, 32'h33);
      usdbr_far_end_inst.strobe(2);
      rdc(LS_OFS, LS | 32'h10);
      rdc(DATA_OFS, 32'h33);
      rdc(LS_OFS, LS);
      usdbr_far_end_inst.strobe(2);
      rdc(LS_OFS, LS);
   endtask : t_idle

   task automatic t_err;
      wr(CTRL_OFS, 32'h8000);
      usdbr_far_end_inst.send(9'h044, 1'b1, 1'b1, 1'b1);
      rdc(LS_OFS, LS | 32'h27);
      chk({31'h0, irq_req}, 32'h0);
      wr(CTRL_OFS, 32'h8080);
      @(negedge aclk);
      chk({31'h0, irq_req}, 32'h1);
      chk({16'h0, ctrl}, 32'h8080);
      rdc(DATA_OFS, 32'h44);
      rdc(LS_OFS, LS);
      chk({31'h0, irq_req}, 32'h0);
   endtask : t_err

   task automatic t_tx;
      wr(DATA_OFS, 32'h1A5);
      @(negedge aclk);
      chk({23'h0, tx_word}, 32'h0A5);
      chk({31'h0, tx_word_valid}, 32'h1);
      usdbr_far_end_inst.strobe(1);
      rdc(LS_OFS, LS);
      usdbr_far_end_inst.strobe(0);
      rdc(LS_OFS, LS | 32'h80);
      chk({31'h0, tx_word_valid}, 32'h0);
      usdbr_far_end_inst.strobe(1);
      rdc(LS_OFS, LS | 32'hC0);
      wr(DATA_OFS, 32'h055);
      rdc(LS_OFS, LS);
      usdbr_far_end_inst.strobe(0);
      usdbr_far_end_inst.strobe(1);
      wr(LS_OFS, 32'h0);
      rdc(LS_OFS, LS | 32'h80);
   endtask : t_tx

   task automatic t_par;
      wr(CTRL_OFS, 32'h4);
      chk({16'h0, ctrl}, 32'h4);
      wr(DATA_OFS, 32'h183);
      @(negedge aclk);
      chk({23'h0, tx_word}, 32'h003);
      wr(DATA_OFS, 32'h007);
      @(negedge aclk);
      chk({23'h0, tx_word}, 32'h087);
      wr(CTRL_OFS, 32'hC);
      wr(DATA_OFS, 32'h007);
      @(negedge aclk);
      chk({23'h0, tx_word}, 32'h007);
   endtask : t_par

   task automatic t_evt;
      wr(CTRL_OFS, 32'h2040);
      usdbr_far_end_inst.strobe(3);
      rdc(LS_OFS, LS | 32'h100);
      chk({31'h0, irq_req}, 32'h1);
      wr(LS_OFS, 32'h0);
      @(posedge aclk);
      @(negedge aclk);
      chk({31'h0, irq_req}, 32'h0);
      usdbr_far_end_inst.cts_flip();
      repeat (5) @(posedge aclk);
      rdc(LS_OFS, LS | 32'h200);
      wr(LS_OFS, 32'h0);
      rdc(LS_OFS, LS);
   endtask : t_evt

   task automatic t_baud;
      int t, b;
      wr(DIV_OFS, 32'hFFFF_1234);
      rdc(DIV_OFS, 32'h1234);
      wstrb <= 4'h1;
      wr(DIV_OFS, 32'h0000_00CD);
      wstrb <= 4'hF;
      rdc(DIV_OFS, 32'h12CD);
      wr(DIV_OFS, 32'h20);
      wr(CTRL_OFS, 32'h1);
      ticks(64, t, b);
      chk(nr(t, 32), 32'd32);
      wr(CTRL_OFS, 32'h21);
      wr(DIV_OFS, 32'h28);
      ticks(64, t, b);
      chk(nr(t, 32), 32'd32);
      wr(CTRL_OFS, 32'h1);
      ticks(64, t, b);
      chk(nr(t, 26), 32'd26);
      wr(DIV_OFS, 32'h10);
      wr(CTRL_OFS, 32'h2);
      ticks(128, t, b);
      chk(32'(t), 32'd0);
      chk(nr(b, 8), 32'd8);
      wr(CTRL_OFS, 32'h22);
      ticks(128, t, b);
      chk(nr(b, 16), 32'd16);
   endtask : t_baud

   // ****************************************
   // sequence and verdict
   // ****************************************
   task automatic test_done;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done

   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
      {awaddr, araddr} = 8'h0;
      wdata = 32'h0;
      wstrb = 4'hF;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(LS_OFS, LS_RESET);
      rdc(DIV_OFS, 32'h0);
      t_rx();
      t_idle();
      t_err();
      t_tx();
      t_par();
      t_evt();
      t_baud();
      test_done();
   end

   // whole run is under a thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      test_done();
   end
endmodule : usdbr_regs_tb
